/* File: rtl/edge_ctrl_pkg.sv */
// package: constants and types for the port clock edge and ready control
package edge_ctrl_pkg;
   // register offsets (byte addresses)
   localparam logic [4:0] CTRL_OFF        = 5'h00;
   localparam logic [4:0] FALL_DLY_OFF    = 5'h04;
   localparam logic [4:0] RISE_DLY_OFF    = 5'h08;
   localparam logic [4:0] READY_SRC_OFF   = 5'h0c;
   localparam logic [4:0] STAT_OFF        = 5'h10;
   localparam logic [4:0] MASK_OFF        = 5'h14;
   localparam logic [4:0] CMD_REG_OFF     = 5'h18;
   localparam logic [4:0] STATE_OFF       = 5'h1c;
   // command codes written to the command register
   localparam logic [2:0] CMD_ON          = 3'h1;
   localparam logic [2:0] CMD_OFF         = 3'h2;
   localparam logic [2:0] CMD_FALL        = 3'h3;
   localparam logic [2:0] CMD_RISE        = 3'h4;
   localparam logic [2:0] CMD_READY       = 3'h5;
   localparam logic [2:0] CMD_HALF        = 3'h6;
   // field positions inside the command word
   localparam int         CMD_ARG_LSB     = 8;
   localparam int         CMD_WIDTH_LSB   = 24;
   // delay limits and defaults
   localparam logic [9:0] DLY_MAX         = 10'h200;
   localparam logic [9:0] DLY_RST         = 10'h000;
   localparam logic [9:0] HALF_RST        = 10'h001;
   localparam logic [3:0] READY_SRC_RST   = 4'h0;
   localparam logic [5:0] READY_WIDTH     = 6'h01;
   // interrupt status bits
   localparam int         IRQ_EXC         = 0;
   localparam int         IRQ_DONE        = 1;

   typedef struct packed {
      logic       on;
      logic [9:0] fall_dly;
      logic [9:0] rise_dly;
      logic [9:0] half_per;
      logic       rdy_en;
      logic [3:0] rdy_src;
   } clk_cfg_t;

   localparam clk_cfg_t CFG_RST = '{on: 1'b0, fall_dly: DLY_RST, rise_dly: DLY_RST,
                                    half_per: HALF_RST, rdy_en: 1'b0, rdy_src: READY_SRC_RST};
   localparam clk_cfg_t CFG_DEF = '{on: 1'b1, fall_dly: DLY_RST, rise_dly: DLY_RST,
                                    half_per: HALF_RST, rdy_en: 1'b0, rdy_src: READY_SRC_RST};
endpackage

/* File: rtl/port_clock_edge_ready_ctrl.sv */
// top module: edge delay, ready-in selection and on/off control of a port clock
// Operation
// [RULE_01] every falling edge of the generated clock is held back by the programmed cycle count before ports see it.
// [RULE_02] after the clock is initialised the falling delay is zero.
// [RULE_03] the falling delay accepts 0 to 512 inclusive and software programs only that range.
// [RULE_04] a falling delay longer than the clock period removes all falling edges at the ports.
// [RULE_05] a ready source whose port is not one bit wide is refused with an exception.
// [RULE_06] the selected ready port level decides on which edges pin data is sampled.
// [RULE_07] software applies the ready selection together with the other port settings in proper order.
// [RULE_08] turning on an off clock enables it and loads every setting with its default.
// [RULE_09] turning on a running clock returns every setting to its default.
// [RULE_10] turning off a clock that is already off changes nothing.
// [RULE_11] any use of a clock that is off is rejected with an exception.
// [RULE_12] the rising delay defaults to zero, accepts 0 to 512, and removes rising edges beyond the period.
// [RULE_13] each exception is a one-cycle pulse and the rejected change is not applied.
`timescale 1ns/1ps
module port_clock_edge_ready_ctrl
   import edge_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        ARST_N_I,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [4:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // ports
   input  wire logic [15:0] READY_PINS_I,
   output logic             PORT_CLK_O,
   output logic             PORT_SAMPLE_O,
   // processor core
   output logic             EXCEPTION_O,
   output logic             IRQ_O
);

   // configuration and bus
   clk_cfg_t    cfg_r;
   logic        req;
   logic        wr_req;
   logic        rd_req;
   logic        ack_r;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;

   // command fields and checks
   logic [2:0]  cmd;
   logic [9:0]  arg;
   logic [5:0]  width;
   logic        cmd_valid;
   logic        exc_nxt;
   logic        exc_r;
   logic        done_nxt;

   // status, mask and interrupt
   logic [1:0]  stat_r;
   logic [1:0]  mask_r;
   logic [1:0]  evt_set;
   logic        stat_clr;
   logic        irq_r;

   // source clock and edge events
   logic        src_clk_r;
   logic [9:0]  half_cnt_r;
   logic        src_wrap;
   logic        rise_evt;
   logic        fall_evt;

   // delayed edges at the ports
   logic [9:0]  since_rise_r;
   logic [9:0]  since_fall_r;
   logic        rise_seen_r;
   logic        fall_seen_r;
   logic        rise_fire;
   logic        fall_fire;
   logic        port_clk_r;

   // ready-in gating
   logic        rdy_level;
   logic        sample_r;

   // bus qualifiers
   assign req    = WB_CYC_I & WB_STB_I & ~ack_r;
   assign wr_req = req & WB_WE_I & (&WB_SEL_I);
   assign rd_req = req & ~WB_WE_I;

   // command word fields
   assign cmd    = WB_DAT_I[2:0];
   assign arg    = WB_DAT_I[CMD_ARG_LSB +: 10];
   assign width  = WB_DAT_I[CMD_WIDTH_LSB +: 6];
   assign cmd_valid = wr_req & (WB_ADR_I == CMD_REG_OFF);

   // command decode and checks
   always_comb begin
      exc_nxt  = 1'b0;
      done_nxt = 1'b0;
      if (cmd_valid) begin
         unique case (cmd)
            CMD_ON:  done_nxt = 1'b1;                                                 // [RULE_08] [RULE_09]
            CMD_OFF: done_nxt = cfg_r.on;                                             // [RULE_10]
            CMD_FALL, CMD_RISE, CMD_HALF: begin
               if (!cfg_r.on) exc_nxt = 1'b1;                                         // [RULE_11]
               else if (arg > DLY_MAX) exc_nxt = 1'b1;                                // [RULE_03]
               else done_nxt = 1'b1;
            end
            CMD_READY: begin
               if (!cfg_r.on) exc_nxt = 1'b1;                                         // [RULE_11]
               else if (width != READY_WIDTH) exc_nxt = 1'b1;                         // [RULE_05]
               else done_nxt = 1'b1;
            end
            default: exc_nxt = 1'b1;
         endcase
      end
   end

   // clock configuration state
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg_r <= CFG_RST;
      end else if (cmd_valid && !exc_nxt) begin                                      // [RULE_13]
         unique case (cmd)
            CMD_ON:    cfg_r <= CFG_DEF;                                              // [RULE_08] [RULE_09] [RULE_02]
            CMD_OFF:   cfg_r.on <= 1'b0;                                              // [RULE_10]
            CMD_FALL:  cfg_r.fall_dly <= arg;                                         // [RULE_01]
            CMD_RISE:  cfg_r.rise_dly <= arg;                                         // [RULE_12]
            CMD_HALF:  cfg_r.half_per <= (arg == 10'h000) ? HALF_RST : arg;
            CMD_READY: begin
               cfg_r.rdy_en  <= 1'b1;
               cfg_r.rdy_src <= arg[3:0];
            end
            default:   cfg_r <= cfg_r;
         endcase
      end
   end

   // exception pulse
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         exc_r <= 1'b0;
      end else begin
         exc_r <= exc_nxt;                                                            // [RULE_13]
      end
   end

   // source edge events, seen one cycle before the toggle
   assign src_wrap = cfg_r.on & (half_cnt_r + 10'h001 >= cfg_r.half_per);
   assign rise_evt = src_wrap & ~src_clk_r;
   assign fall_evt = src_wrap & src_clk_r;

   // source clock: toggles every half_per cycles while on
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         src_clk_r  <= 1'b0;
         half_cnt_r <= 10'h000;
      end else if (!cfg_r.on) begin
         src_clk_r  <= 1'b0;
         half_cnt_r <= 10'h000;
      end else if (src_wrap) begin
         src_clk_r  <= ~src_clk_r;
         half_cnt_r <= 10'h000;
      end else begin
         half_cnt_r <= half_cnt_r + 10'h001;
      end
   end

   // rising edge tracking: a pending edge lives for one full source period
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         since_rise_r <= 10'h000;
         rise_seen_r  <= 1'b0;
      end else if (!cfg_r.on) begin
         since_rise_r <= 10'h000;
         rise_seen_r  <= 1'b0;
      end else if (rise_evt) begin
         since_rise_r <= 10'h000;
         rise_seen_r  <= 1'b1;
      end else begin
         if (since_rise_r != 10'h3ff) since_rise_r <= since_rise_r + 10'h001;
         if (rise_fire) rise_seen_r <= 1'b0;
      end
   end

   // falling edge tracking: a pending edge lives for one full source period
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         since_fall_r <= 10'h000;
         fall_seen_r  <= 1'b0;
      end else if (!cfg_r.on) begin
         since_fall_r <= 10'h000;
         fall_seen_r  <= 1'b0;
      end else if (fall_evt) begin
         since_fall_r <= 10'h000;
         fall_seen_r  <= 1'b1;
      end else begin
         if (since_fall_r != 10'h3ff) since_fall_r <= since_fall_r + 10'h001;
         if (fall_fire) fall_seen_r <= 1'b0;
      end
   end

   // delayed edges; a pending edge is lost when the next edge of its kind comes,
   // so a delay of a full source period or more shows no edge of that kind
   assign rise_fire = rise_seen_r & (since_rise_r == cfg_r.rise_dly);                // [RULE_12]
   assign fall_fire = fall_seen_r & (since_fall_r == cfg_r.fall_dly);                // [RULE_01] [RULE_04]

   // port clock as seen by ports
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         port_clk_r <= 1'b0;
      end else if (!cfg_r.on) begin
         port_clk_r <= 1'b0;
      end else if (rise_fire) begin
         port_clk_r <= 1'b1;                                                          // [RULE_12]
      end else if (fall_fire) begin
         port_clk_r <= 1'b0;                                                          // [RULE_01] [RULE_04]
      end
   end

   // ready-in gated sample strobe on each delivered rising edge
   assign rdy_level = READY_PINS_I[cfg_r.rdy_src];
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sample_r <= 1'b0;
      end else begin
         sample_r <= cfg_r.on & rise_fire & (~cfg_r.rdy_en | rdy_level);             // [RULE_06]
      end
   end

   // sticky status, read clears, set wins
   assign evt_set[IRQ_EXC]  = exc_nxt;
   assign evt_set[IRQ_DONE] = done_nxt;
   assign stat_clr          = rd_req & (WB_ADR_I == STAT_OFF);
   for (genvar gi = 0; gi < 2; gi++) begin : g_stat
      always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
         if (!ARST_N_I) begin
            stat_r[gi] <= 1'b0;
         end else if (evt_set[gi]) begin
            stat_r[gi] <= 1'b1;
         end else if (stat_clr) begin
            stat_r[gi] <= 1'b0;
         end
      end
   end

   // mask register
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask_r <= 2'h0;
      end else if (wr_req && WB_ADR_I == MASK_OFF) begin
         mask_r <= WB_DAT_I[1:0];
      end
   end

   // level interrupt, registered
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & mask_r);
      end
   end

   // read data select
   always_comb begin
      dat_nxt = 32'h0;
      if (rd_req) begin
         unique case (WB_ADR_I)
            CTRL_OFF:      dat_nxt = {31'h0, cfg_r.on};
            FALL_DLY_OFF:  dat_nxt = {22'h0, cfg_r.fall_dly};
            RISE_DLY_OFF:  dat_nxt = {22'h0, cfg_r.rise_dly};
            READY_SRC_OFF: dat_nxt = {27'h0, cfg_r.rdy_en, cfg_r.rdy_src};
            STAT_OFF:      dat_nxt = {30'h0, stat_r};
            MASK_OFF:      dat_nxt = {30'h0, mask_r};
            STATE_OFF:     dat_nxt = {22'h0, cfg_r.half_per};
            default:       dat_nxt = 32'h0;
         endcase
      end
   end

   // bus answer: one wait-free ack, read data registered
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         ack_r <= req;
         dat_r <= dat_nxt;
      end
   end

   // outputs
   assign WB_ACK_O      = ack_r;
   assign WB_DAT_O      = dat_r;
   assign PORT_CLK_O    = port_clk_r;
   assign PORT_SAMPLE_O = sample_r;
   assign EXCEPTION_O   = exc_r;
   assign IRQ_O         = irq_r;

endmodule // port_clock_edge_ready_ctrl

/* File: testbench/ready_port_model.sv */
// partner: one-bit ports that feed the ready pins
`timescale 1ns/1ps
module ready_port_model (
   input  wire logic        lvl_i,
   input  wire logic [15:0] noise_i,
   output wire logic [15:0] pins_o
);
   // port three carries the chosen ready level, the rest wander
   assign pins_o = {noise_i[15:4], lvl_i, noise_i[2:0]};
endmodule // ready_port_model

/* File: testbench/edge_ctrl_assertions.sv */
// checker: bus, exception and sample pulse assertions
`timescale 1ns/1ps
module edge_ctrl_checker
   import edge_ctrl_pkg::*;
(
   input wire logic        CORE_CLK_I,
   input wire logic        ARST_N_I,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [4:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic        WB_ACK_O,
   input wire logic        PORT_SAMPLE_O,
   input wire logic        EXCEPTION_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   wire logic       cw = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == CMD_REG_OFF && WB_SEL_I == 4'hf;
   wire logic [2:0] cc = WB_DAT_I[2:0];
   ack_follows_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
   ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   exc_pulse_a: assert property (EXCEPTION_O |=> !EXCEPTION_O) else $error("exception too long");
   exc_cause_a: assert property (EXCEPTION_O |-> WB_ACK_O && $past(cw)) else $error("stray exception");
   off_quiet_a: assert property (WB_ACK_O && $past(cw && cc == CMD_OFF) |-> !EXCEPTION_O) else $error("off raised");
   on_quiet_a: assert property (WB_ACK_O && $past(cw && cc == CMD_ON) |-> !EXCEPTION_O) else $error("on raised");
   dly_range_a: assert property (WB_ACK_O && $past(cw && (cc == CMD_FALL || cc == CMD_RISE) && WB_DAT_I[17:8] > DLY_MAX)
      |-> EXCEPTION_O) else $error("delay over range accepted");
   ready_width_a: assert property (WB_ACK_O && $past(cw && cc == CMD_READY && WB_DAT_I[29:24] != READY_WIDTH)
      |-> EXCEPTION_O) else $error("wide ready port accepted");
   sample_pulse_a: assert property (PORT_SAMPLE_O |=> !PORT_SAMPLE_O) else $error("sample pulse too long");
endmodule // edge_ctrl_checker
bind port_clock_edge_ready_ctrl edge_ctrl_checker edge_ctrl_checker_inst (.CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .PORT_SAMPLE_O(PORT_SAMPLE_O), .EXCEPTION_O(EXCEPTION_O));

/* File: testbench/port_clock_edge_ready_ctrl_tb.sv */
// testbench: command, edge delay, ready and interrupt scenarios
`timescale 1ns/1ps
module port_clock_edge_ready_ctrl_tb;
   import edge_ctrl_pkg::*;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, lvl = 0;
   logic [4:0]  adr = '0;
   logic [31:0] dat = '0, rdat;
   logic [15:0] noise = '0, pins;
   logic [3:0]  sel = 4'hf;
   logic        ack, pclk, smp, exc, irq;
   logic [65:0] q[$], t;
   int          error_cnt = 0, samples_checked = 0, seed = 31, cycles = 0, n;
   always #5 clk = ~clk;
   always @(posedge clk) noise <= 16'($random(seed));
   ready_port_model ready_port_model_inst (.lvl_i(lvl), .noise_i(noise), .pins_o(pins));
   port_clock_edge_ready_ctrl port_clock_edge_ready_ctrl_inst (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .READY_PINS_I(pins), .PORT_CLK_O(pclk), .PORT_SAMPLE_O(smp), .EXCEPTION_O(exc), .IRQ_O(irq));
   task automatic final_report();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [32:0] g, e, m);
      samples_checked++;
      if ((g & m) !== (e & m)) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, g & m, e & m);
      end
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [32:0] e, m);
      q.push_back({e, m});
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cmd(input logic [2:0] c, input logic [9:0] g, input logic [5:0] w, input logic x);
      wb(1'b1, 5'h18, {2'b00, w, 6'h00, g, 5'h00, c}, {x, 32'h0}, {1'b1, 32'h0});
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, m);
      wb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
   endtask
   task automatic hi_time(output int c);
      do @(posedge clk); while (pclk !== 1'b0);
      do @(posedge clk); while (pclk !== 1'b1);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (pclk === 1'b1 && c < 60);
   endtask
   // counts sample pulses, or low port clock cycles, over 40 cycles after settling
   task automatic count(input logic pulses, output int c);
      c = 0;
      repeat (16) @(posedge clk);
      repeat (40) begin
         @(posedge clk);
         if (pulses ? smp === 1'b1 : pclk === 1'b0)
            c++;
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (ack === 1'b1) begin
         t = q.pop_front();
         chk({exc, rdat}, t[65:33], t[32:0]);
      end
      if (cycles == 6000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cmd(CMD_FALL, 10'h003, 6'h00, 1'b1);
      rd(5'h04, 32'h0, '1);
      wb(1'b1, 5'h14, 32'h1, 33'h0, 33'h0);
      repeat (2) @(posedge clk);
      chk({32'h0, irq}, 33'h1, 33'h1);
      rd(5'h10, 32'h1, 32'h1);
      repeat (2) @(posedge clk);
      chk({32'h0, irq}, 33'h0, 33'h1);
      sel <= 4'h1;
      wb(1'b1, 5'h14, 32'h2, 33'h0, 33'h0);
      sel <= 4'hf;
      rd(5'h14, 32'h1, '1);
      cmd(CMD_OFF, 10'h000, 6'h00, 1'b0);
      cmd(CMD_ON, 10'h000, 6'h00, 1'b0);
      rd(5'h00, 32'h1, 32'h1);
      rd(5'h04, 32'h0, '1);
      cmd(CMD_HALF, 10'h004, 6'h00, 1'b0);
      cmd(CMD_FALL, 10'h002, 6'h00, 1'b0);
      hi_time(n);
      chk(33'(n), 33'd6, '1);
      cmd(CMD_RISE, 10'h003, 6'h00, 1'b0);
      hi_time(n);
      chk(33'(n), 33'd3, '1);
      cmd(CMD_RISE, 10'h000, 6'h00, 1'b0);
      cmd(CMD_FALL, 10'h009, 6'h00, 1'b0);
      count(1'b0, n);
      chk(33'(n), 33'd0, '1);
      n = {$random(seed)} % 513;
      cmd(CMD_FALL, n[9:0], 6'h00, 1'b0);
      rd(5'h04, 32'(n), '1);
      cmd(CMD_FALL, 10'h200, 6'h00, 1'b0);
      cmd(CMD_FALL, 10'h201, 6'h00, 1'b1);
      rd(5'h04, 32'h200, '1);
      cmd(CMD_RISE, 10'h201, 6'h00, 1'b1);
      cmd(CMD_FALL, 10'h000, 6'h00, 1'b0);
      cmd(CMD_READY, 10'h003, 6'h02, 1'b1);
      rd(5'h0c, 32'h0, '1);
      cmd(CMD_READY, 10'h003, 6'h01, 1'b0);
      rd(5'h0c, 32'h13, '1);
      count(1'b1, n);
      chk(33'(n), 33'd0, '1);
      lvl <= 1'b1;
      count(1'b1, n);
      chk(33'(n), 33'd5, '1);
      cmd(CMD_ON, 10'h000, 6'h00, 1'b0);
      rd(5'h04, 32'h0, '1);
      rd(5'h0c, 32'h0, '1);
      rd(5'h1c, 32'h1, '1);
      cmd(CMD_OFF, 10'h000, 6'h00, 1'b0);
      cmd(CMD_OFF, 10'h000, 6'h00, 1'b0);
      cmd(CMD_HALF, 10'h002, 6'h00, 1'b1);
      final_report();
   end
endmodule // port_clock_edge_ready_ctrl_tb
